// ==== logic/smask_pkg.sv ====
// Purpose: Shared constants and types for the second alert source mask block
// Assumes: Word registers travel low byte first over the two-wire management bus
// Notes: The bus address default is arbitrary and is overridden per board
`default_nettype none

package smask_pkg;

   // Command code and the word behind it
   localparam logic [7:0] CMD_SECOND_ALERT_MASK = 8'hD6;
   localparam logic [15:0] MASK_RESET = 16'h8000;
   // Bit 2 is reserved and always reads as zero
   localparam logic [15:0] MASK_WRITABLE = 16'hFFFB;

   // Field positions inside the mask word
   localparam int BIT_PASS_SWITCH_DEGRADED = 15;
   localparam int BIT_OVERCURRENT_FAULT = 14;
   localparam int BIT_INPUT_OV_FAULT = 13;
   localparam int BIT_INPUT_UV_FAULT = 12;
   localparam int BIT_BUS_COMM_ERROR = 11;
   localparam int BIT_OVERCURRENT_WARN = 10;
   localparam int BIT_SECONDARY_CURRENT_WARN = 9;
   localparam int BIT_INPUT_OV_WARN = 8;
   localparam int BIT_INPUT_UV_WARN = 7;
   localparam int BIT_OUTPUT_OV_WARN = 6;
   localparam int BIT_OUTPUT_UV_WARN = 5;
   localparam int BIT_CURRENT_LIMIT_ACTIVE = 4;
   localparam int BIT_ALERT_POLARITY_INVERT = 3;
   localparam int BIT_OUTPUT_PIN_GENERAL_SELECT = 1;
   localparam int BIT_OUTPUT_PIN_LEVEL = 0;
   localparam int SOURCE_COUNT = 12;

   // Seven-bit bus address, value arbitrary
   localparam logic [6:0] BUS_ADDR_DEFAULT = 7'h10;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [3:0] LAST_BIT = 4'h7;

   // Position of the byte inside a transfer
   localparam logic [1:0] IDX_ADDR = 2'h0;
   localparam logic [1:0] IDX_CMD = 2'h1;
   localparam logic [1:0] IDX_DATA_LO = 2'h2;
   localparam logic [1:0] IDX_DATA_HI = 2'h3;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_RX,
      ST_RX_ACK,
      ST_TX,
      ST_TX_ACK
   } smask_state_e;

endpackage

`default_nettype wire

// ==== logic/smask_sync.sv ====
// Purpose: Two-flop synchroniser for pins arriving from outside the clock domain
// Assumes: Inputs are quasi-static levels relative to mclk
// Notes: Only the second stage is visible to the caller
`default_nettype none

module smask_sync
   import smask_pkg::*;
#(
   parameter int WIDTH = 2,
   parameter logic [WIDTH-1:0] INIT = '1
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   typedef struct packed {
      logic [WIDTH-1:0] stage1;
      logic [WIDTH-1:0] stage2;
   } smask_sync_s;

   smask_sync_s q;
   smask_sync_s d;

   initial begin
      if (WIDTH < 1) begin
         $error("smask_sync: WIDTH must be at least 1");
      end
   end

   always_comb begin
      d = q;
      d.stage1 = async_in;
      d.stage2 = q.stage1;
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         q <= '{stage1: INIT, stage2: INIT};
      end else begin
         q <= d;
      end
   end

   assign sync_out = q.stage2;

endmodule

`default_nettype wire

// ==== logic/smask_top.sv ====
// Purpose: Second alert output with its source mask word, reached over the management bus
// Assumes: Status flags come from logic on mclk; bus clock and data are pins
// Notes: Word transfers are low byte first; the data pin is open-drain
`default_nettype none

module smask_top
   import smask_pkg::*;
#(
   parameter logic [6:0] BUS_ADDR = BUS_ADDR_DEFAULT
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   input wire logic pass_switch_degraded_flag,
   input wire logic overcurrent_fault_flag,
   input wire logic input_overvoltage_fault_flag,
   input wire logic input_undervoltage_fault_flag,
   input wire logic bus_communication_error_flag,
   input wire logic overcurrent_warning_flag,
   input wire logic secondary_current_warning_flag,
   input wire logic input_overvoltage_warning_flag,
   input wire logic input_undervoltage_warning_flag,
   input wire logic output_overvoltage_warning_flag,
   input wire logic output_undervoltage_warning_flag,
   input wire logic current_limit_active_flag,
   output logic second_alert_pin,
   output logic alert_active,
   output logic [15:0] mask_word
);

   typedef struct packed {
      smask_state_e state;
      logic [3:0] cnt;
      logic [1:0] idx;
      logic [7:0] shift;
      logic [7:0] tx;
      logic [7:0] data_lo;
      logic [15:0] mask;
      logic rd;
      logic tx_hi;
      logic acked;
      logic cmd_hit;
      logic scl_p;
      logic sda_p;
      logic sda_oe;
      logic pin;
      logic active;
   } smask_top_s;

   smask_top_s q;
   smask_top_s d;

   // Addresses 0000xxx and 1111xxx are reserved on the two-wire bus
   if (BUS_ADDR[6:3] == 4'h0 || BUS_ADDR[6:3] == 4'hF) begin : g_bad_addr
      $error("smask_top: BUS_ADDR falls in a reserved address range");
   end

   // True when the byte carries this block's own address
   function automatic logic addr_hit(input logic [7:0] b);
      return b[7:1] == BUS_ADDR;
   endfunction

   // True when the command byte selects the mask word
   function automatic logic is_mask_cmd(input logic [7:0] b);
      return b == CMD_SECOND_ALERT_MASK;
   endfunction

   // Pin level for a mask word and the combined source state
   function automatic logic pin_level(input logic [15:0] m, input logic act);
      logic lvl;
      if (m[BIT_OUTPUT_PIN_GENERAL_SELECT]) begin
         // General output mode ignores every source
         lvl = m[BIT_OUTPUT_PIN_LEVEL];
      end else begin
         // Polarity bit clear means the alert pulls the pin low
         lvl = m[BIT_ALERT_POLARITY_INVERT] ? act : ~act;
      end
      return lvl;
   endfunction

   logic [1:0] pins_s;
   logic scl_s;
   logic sda_s;
   logic scl_rise;
   logic scl_fall;
   logic bus_start;
   logic bus_stop;
   logic [SOURCE_COUNT-1:0] sources;
   logic [SOURCE_COUNT-1:0] enables;
   logic any_source;

   smask_sync #(
      .WIDTH(2),
      .INIT(2'h3)
   ) u_sync (
      .mclk(mclk),
      .rst(rst),
      .async_in({scl_i, sda_i}),
      .sync_out(pins_s)
   );

   assign scl_s = pins_s[1];
   assign sda_s = pins_s[0];
   assign scl_rise = scl_s & ~q.scl_p;
   assign scl_fall = ~scl_s & q.scl_p;
   assign bus_start = scl_s & q.scl_p & q.sda_p & ~sda_s;
   assign bus_stop = scl_s & q.scl_p & ~q.sda_p & sda_s;

   // Sources in the same order as their enables, bit 15 downward
   assign sources = {
      pass_switch_degraded_flag,
      overcurrent_fault_flag,
      input_overvoltage_fault_flag,
      input_undervoltage_fault_flag,
      bus_communication_error_flag,
      overcurrent_warning_flag,
      secondary_current_warning_flag,
      input_overvoltage_warning_flag,
      input_undervoltage_warning_flag,
      output_overvoltage_warning_flag,
      output_undervoltage_warning_flag,
      current_limit_active_flag
   };
   // Enables only gate the flags; the flags themselves are never touched here
   assign enables = q.mask[BIT_PASS_SWITCH_DEGRADED:BIT_CURRENT_LIMIT_ACTIVE];
   // Level follows the flags, so the alert stays while any enabled flag is set
   assign any_source = |(sources & enables);

   // One pass decides bus state, data drive and alert pin
   always_comb begin
      d = q;
      d.scl_p = scl_s;
      d.sda_p = sda_s;
      if (bus_stop) begin
         d.state = ST_IDLE;
         d.sda_oe = 1'b0;
         d.cmd_hit = 1'b0;
      end else if (bus_start) begin
         // Repeated start keeps the command so a word read can follow
         d.state = ST_RX;
         d.cnt = '0;
         d.idx = IDX_ADDR;
         d.rd = 1'b0;
         d.tx_hi = 1'b0;
         d.sda_oe = 1'b0;
      end else begin
         unique case (q.state)
            ST_IDLE: begin
               d.sda_oe = 1'b0;
            end
            ST_RX: begin
               if (scl_rise && q.cnt != BITS_PER_BYTE) begin
                  d.shift = {q.shift[6:0], sda_s};
                  d.cnt = q.cnt + 4'h1;
               end else if (scl_fall && q.cnt == BITS_PER_BYTE) begin
                  d.cnt = '0;
                  d.state = ST_IDLE;
                  d.sda_oe = 1'b0;
                  unique case (q.idx)
                     IDX_ADDR: begin
                        if (addr_hit(q.shift)) begin
                           if (!q.shift[0]) begin
                              d.state = ST_RX_ACK;
                              d.sda_oe = 1'b1;
                           end else if (q.cmd_hit) begin
                              d.rd = 1'b1;
                              d.tx = q.mask[7:0];
                              d.state = ST_RX_ACK;
                              d.sda_oe = 1'b1;
                           end
                        end
                     end
                     IDX_CMD: begin
                        // Only this block's command is acknowledged
                        d.cmd_hit = is_mask_cmd(q.shift);
                        if (is_mask_cmd(q.shift)) begin
                           d.state = ST_RX_ACK;
                           d.sda_oe = 1'b1;
                        end
                     end
                     IDX_DATA_LO: begin
                        d.data_lo = q.shift;
                        d.state = ST_RX_ACK;
                        d.sda_oe = 1'b1;
                     end
                     IDX_DATA_HI: begin
                        // Word commits only once both bytes have arrived
                        d.mask = {q.shift, q.data_lo} & MASK_WRITABLE;
                        d.state = ST_RX_ACK;
                        d.sda_oe = 1'b1;
                     end
                  endcase
               end
            end
            ST_RX_ACK: begin
               if (scl_fall) begin
                  d.cnt = '0;
                  if (q.rd) begin
                     d.state = ST_TX;
                     d.sda_oe = ~q.tx[7];
                  end else if (q.idx == IDX_DATA_HI) begin
                     // Further bytes go unacknowledged
                     d.state = ST_IDLE;
                     d.sda_oe = 1'b0;
                  end else begin
                     d.state = ST_RX;
                     d.idx = q.idx + 2'h1;
                     d.sda_oe = 1'b0;
                  end
               end
            end
            ST_TX: begin
               if (scl_fall) begin
                  if (q.cnt == LAST_BIT) begin
                     d.state = ST_TX_ACK;
                     d.sda_oe = 1'b0;
                     d.acked = 1'b0;
                  end else begin
                     d.cnt = q.cnt + 4'h1;
                     d.tx = {q.tx[6:0], 1'b0};
                     d.sda_oe = ~q.tx[6];
                  end
               end
            end
            ST_TX_ACK: begin
               if (scl_rise) begin
                  d.acked = ~sda_s;
               end else if (scl_fall) begin
                  d.cnt = '0;
                  if (q.acked && !q.tx_hi) begin
                     d.state = ST_TX;
                     d.tx_hi = 1'b1;
                     d.tx = q.mask[15:8];
                     d.sda_oe = ~q.mask[15];
                  end else begin
                     d.state = ST_IDLE;
                     d.sda_oe = 1'b0;
                  end
               end
            end
         endcase
      end
      d.active = any_source;
      d.pin = pin_level(q.mask, any_source);
   end

   // Reset leaves the pin at its idle level with only bit 15 enabled
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         q <= '{
            state: ST_IDLE,
            cnt: 4'h0,
            idx: IDX_ADDR,
            shift: 8'h00,
            tx: 8'h00,
            data_lo: 8'h00,
            mask: MASK_RESET,
            rd: 1'b0,
            tx_hi: 1'b0,
            acked: 1'b0,
            cmd_hit: 1'b0,
            scl_p: 1'b1,
            sda_p: 1'b1,
            sda_oe: 1'b0,
            pin: 1'b1,
            active: 1'b0
         };
      end else begin
         q <= d;
      end
   end

   // Open drain: only a low level is ever driven
   assign sda_o = 1'b0;
   assign sda_oe = q.sda_oe;
   assign second_alert_pin = q.pin;
   assign alert_active = q.active;
   assign mask_word = q.mask;

endmodule

`default_nettype wire

// ==== sim/smask_asserts.sv ====
// Purpose: Assertions on the alert pin, its modes and the mask word
// Assumes: Bound into smask_top; one clock domain
// Notes: Bus checks hold the mask and the data drive still while the bus clock is high
`default_nettype none
module smask_asserts
   import smask_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic scl_i,
   input wire logic sda_oe,
   input wire logic pass_switch_degraded_flag,
   input wire logic second_alert_pin,
   input wire logic alert_active,
   input wire logic [15:0] mask_word
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge mclk);
   endclocking
   default disable iff (rst);
   a_reset_value: assert property ($fell(rst) |-> mask_word == MASK_RESET)
      else $error("mask word not at reset value");
   a_default_alert: assert property (pass_switch_degraded_flag && mask_word[15] |=> alert_active)
      else $error("pass switch flag gave no alert");
   a_all_masked: assert property (mask_word[15:4] == 12'h000 |=> !alert_active)
      else $error("alert with every source masked");
   a_pin_polarity: assert property (!mask_word[1] |=> second_alert_pin == ($past(mask_word[3]) ~^ alert_active))
      else $error("alert pin level wrong");
   a_pin_general: assert property (mask_word[1] |=> second_alert_pin == $past(mask_word[0]))
      else $error("general output level wrong");
   a_reserved_zero: assert property (mask_word[2] == 1'b0)
      else $error("reserved mask bit set");
   a_mask_update: assert property (!$stable(mask_word) |-> !scl_i)
      else $error("mask changed while bus clock high");
   a_data_stands: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe))
      else $error("data drive changed while bus clock high");
endmodule
bind smask_top smask_asserts smask_asserts_i (.mclk(mclk), .rst(rst), .scl_i(scl_i), .sda_oe(sda_oe),
   .pass_switch_degraded_flag(pass_switch_degraded_flag), .second_alert_pin(second_alert_pin),
   .alert_active(alert_active), .mask_word(mask_word));
`default_nettype wire

// ==== sim/smask_host.sv ====
// Purpose: Bus host model driving clock and data toward the mask block
// Assumes: Data wire is pulled up; one bit takes 16 mclk cycles
// Notes: Clock idles high between frames and moves only on mclk rising edges
`default_nettype none
module smask_host (
   input wire logic mclk,
   input wire logic sda_w,
   output logic scl,
   output logic sda
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      scl = 1'b1;
      sda = 1'b1;
   end
   // Data moves only while the clock is low; the wire is read mid-high
   task automatic bit_x(input logic b, output logic r);
      scl <= 1'b0;
      repeat (4) @(posedge mclk);
      sda <= b;
      repeat (4) @(posedge mclk);
      scl <= 1'b1;
      repeat (4) @(posedge mclk);
      r = sda_w;
      repeat (4) @(posedge mclk);
   endtask
   task automatic start();
      logic r;
      bit_x(1'b1, r);
      sda <= 1'b0;
      repeat (8) @(posedge mclk);
   endtask
   task automatic stop();
      logic r;
      bit_x(1'b0, r);
      sda <= 1'b1;
      repeat (8) @(posedge mclk);
   endtask
   // Byte MSB first, then the acknowledge bit; 1 releases the line
   task automatic xfer(input logic [7:0] d, input logic a_in, output logic [7:0] q, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_x(d[i], q[i]);
      end
      bit_x(a_in, r);
      ack = ~r;
   endtask
endmodule
`default_nettype wire

// ==== sim/smask_top_tb_top.sv ====
// Purpose: Self-checking bench for the second alert mask block
// Assumes: Host model bit time is 16 mclk cycles
// Notes: Flags are plain levels set by the bench
`default_nettype none
module smask_top_tb_top
   import smask_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk, rst, scl, sda, sda_oe, sdo, pin, act, ok, a;
   logic [11:0] fl;
   logic [15:0] mw, v;
   logic [7:0] q;
   int fails = 0;
   int n_checks = 0;
   int cyc = 0;
   wire sda_w = sda & (sda_oe ? sdo : 1'b1);
   smask_top smask_top_i (.mclk(mclk), .rst(rst), .scl_i(scl), .sda_i(sda_w), .sda_o(sdo), .sda_oe(sda_oe),
      .pass_switch_degraded_flag(fl[11]), .overcurrent_fault_flag(fl[10]), .input_overvoltage_fault_flag(fl[9]),
      .input_undervoltage_fault_flag(fl[8]), .bus_communication_error_flag(fl[7]), .overcurrent_warning_flag(fl[6]),
      .secondary_current_warning_flag(fl[5]), .input_overvoltage_warning_flag(fl[4]),
      .input_undervoltage_warning_flag(fl[3]), .output_overvoltage_warning_flag(fl[2]),
      .output_undervoltage_warning_flag(fl[1]), .current_limit_active_flag(fl[0]), .second_alert_pin(pin),
      .alert_active(act), .mask_word(mw));
   smask_host smask_host_i (.mclk(mclk), .sda_w(sda_w), .scl(scl), .sda(sda));
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         fails++;
         stop_test();
      end
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic fset(input logic [11:0] x, input int n);
      @(posedge mclk);
      fl <= x;
      repeat (n) @(posedge mclk);
      @(negedge mclk);
   endtask
   task automatic pre(input logic [7:0] cmd);
      @(posedge mclk);
      smask_host_i.start();
      smask_host_i.xfer({BUS_ADDR_DEFAULT, 1'b0}, 1'b1, q, a);
      smask_host_i.xfer(cmd, 1'b1, q, ok);
      ok &= a;
   endtask
   task automatic wr(input logic [7:0] cmd, input logic [15:0] w);
      pre(cmd);
      smask_host_i.xfer(w[7:0], 1'b1, q, a);
      ok &= a;
      smask_host_i.xfer(w[15:8], 1'b1, q, a);
      ok &= a;
      smask_host_i.stop();
   endtask
   task automatic rd();
      pre(CMD_SECOND_ALERT_MASK);
      smask_host_i.start();
      smask_host_i.xfer({BUS_ADDR_DEFAULT, 1'b1}, 1'b1, q, a);
      smask_host_i.xfer(8'hFF, 1'b0, v[7:0], a);
      smask_host_i.xfer(8'hFF, 1'b1, v[15:8], a);
      smask_host_i.stop();
   endtask
   task automatic t_reset();
      chk(mw, MASK_RESET);
      chk(16'(pin), 16'h0001);
      rd();
      chk(v, 16'h8000);
      fset(12'h800, 3);
      chk(16'(pin), 16'h0000);
      fset(12'h7FF, 3);
      chk(16'(act), 16'h0000);
      $display("reset test done");
   endtask
   task automatic t_src();
      for (int i = 0; i < 12; i++) begin
         wr(CMD_SECOND_ALERT_MASK, 16'h0010 << i);
         chk(16'(ok), 16'h0001);
         chk(mw, 16'h0010 << i);
         fset(~(12'h001 << i), 3);
         chk(16'(act), 16'h0000);
         fset(12'h001 << i, 12);
         chk(16'(pin), 16'h0000);
         fset(12'h000, 3);
         chk(16'(pin), 16'h0001);
      end
      $display("source test done");
   endtask
   task automatic t_cfg();
      wr(CMD_SECOND_ALERT_MASK, 16'h0000);
      fset(12'hFFF, 3);
      chk(16'(act), 16'h0000);
      chk(16'(pin), 16'h0001);
      fset(12'h800, 0);
      wr(CMD_SECOND_ALERT_MASK, 16'h8008);
      chk(16'(pin), 16'h0001);
      wr(CMD_SECOND_ALERT_MASK, 16'h800A);
      chk(16'(pin), 16'h0000);
      wr(CMD_SECOND_ALERT_MASK, 16'hFFFF);
      rd();
      chk(v, MASK_WRITABLE);
      chk(16'(pin), 16'h0001);
      $display("config test done");
   endtask
   task automatic t_ref();
      wr(8'hD5, 16'h1234);
      chk(16'(ok), 16'h0000);
      chk(mw, MASK_WRITABLE);
      smask_host_i.start();
      smask_host_i.xfer({BUS_ADDR_DEFAULT, 1'b1}, 1'b1, q, a);
      smask_host_i.stop();
      chk(16'(a), 16'h0000);
      @(posedge mclk);
      rst <= 1'b1;
      @(posedge mclk);
      rst <= 1'b0;
      fset(12'h800, 4);
      chk(mw, MASK_RESET);
      chk(16'(pin), 16'h0000);
      $display("refusal test done");
   endtask
   task automatic stop_test();
      $display("checks=%0d fails=%0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      rst = 1'b1;
      fl = 12'h000;
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
      repeat (6) @(posedge mclk);
      @(negedge mclk);
      t_reset();
      t_src();
      t_cfg();
      t_ref();
      stop_test();
   end
endmodule
`default_nettype wire
